/* File: src/pmpc_pkg.sv */
// Package with modes, reset values and field constants of the power pin block.
package pmpc_pkg;

	typedef enum logic [2:0] {
		PMPC_HIGH_SPEED,
		PMPC_LOW_SPEED,
		PMPC_DOZE,
		PMPC_SLEEP,
		PMPC_SUSPEND,
		PMPC_OFF
	} pmpc_mode_t;

	localparam int PMPC_NUM_BL = 4;
	localparam int PMPC_NUM_PC = 5;
	localparam int PMPC_NUM_SEL = 4;
	localparam int PMPC_NUM_MODES = 6;
	localparam int PMPC_SYNC_STAGES = 2;

	// Power-control outputs after reset: bit 3 high, the rest low.
	localparam logic [4:0] PMPC_PC_RESET = 5'h08;

	// Source flag positions in the management interrupt status.
	localparam int PMPC_SRC_BL1 = 0;
	localparam int PMPC_SRC_BL2 = 1;
	localparam int PMPC_SRC_BL3 = 2;
	localparam int PMPC_SRC_EXT = 3;
	localparam int PMPC_NUM_SRC = 4;

	// Select-pin mode encodings.
	localparam logic [1:0] PMPC_SEL_DECODE = 2'h0;
	localparam logic [1:0] PMPC_SEL_STROBE = 2'h1;
	localparam logic [1:0] PMPC_SEL_DIRECT = 2'h2;

	localparam logic [3:0] PMPC_SEL_DIR_RESET = 4'hc;
	localparam logic [3:0] PMPC_SEL_OUT_RESET = 4'h0;

endpackage

/* File: src/pmpc_select_pin.sv */
// One programmable select pin: decode, strobe gating, direct and off level.
`timescale 1ns/1ps
module pmpc_select_pin
	import pmpc_pkg::*;
(
	input wire logic [1:0] i_sel_mode,
	input wire logic i_decode_hit,
	input wire logic i_strobe,
	input wire logic i_direct_bit,
	input wire logic i_direct_allowed,
	input wire logic i_off_force,
	input wire logic i_off_level,
	output logic o_level
);

	always_comb begin
		o_level = i_decode_hit;
		if (i_off_force) begin
			o_level = i_off_level;
		end else begin
			case (i_sel_mode)
				PMPC_SEL_STROBE: o_level = i_decode_hit & i_strobe;
				PMPC_SEL_DIRECT: o_level = i_direct_allowed ? i_direct_bit
					: i_decode_hit;
				default: o_level = i_decode_hit;
			endcase
		end
	end

endmodule

/* File: src/pmpc_sync_edge.sv */
// Two-flop synchroniser with rise and fall detection on the synced level.
`timescale 1ns/1ps
module pmpc_sync_edge
	import pmpc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_async,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);

	logic meta;
	logic sync;
	logic prev;
	logic [1:0] fill;
	logic primed;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
		end else begin
			meta <= i_async;
			sync <= meta;
			prev <= sync;
		end
	end

	// Edges are held back until the flops and the history all hold pin
	// samples, so a pin that idles away from the reset value gives no edge.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fill <= 2'h0;
		end else if (!primed) begin
			fill <= fill + 2'h1;
		end
	end

	assign primed = (fill > PMPC_SYNC_STAGES);
	assign o_level = sync;
	assign o_rise = sync & ~prev & primed;
	assign o_fall = ~sync & prev & primed;

endmodule

/* File: src/pmpc_top.sv */
// Power-management pin controller: mode stepping, interrupts and pins.
//
// How it works
// - AC present with override suppresses management.
// - Battery-low inputs act on falling edges.
// - Battery-low 1: low speed or interrupt.
// - Battery-low 2: sleep unless sleeping, or interrupt.
// - Battery-low 3 only raises an interrupt.
// - Battery-low 4 forces suspend when enabled.
// - External input edge raises interrupt, polarity selectable.
// - Latched power equals inverse battery-low 4 when off AC and enabled.
// - Select pins 0,1 bidirectional, reset inputs.
// - Each select pin: decoder or chip select.
// - Pins 0 and 2 gate on writes.
// - Pins 1 and 3 gate on reads.
// - Pins 0 and 1 follow a direct bit.
// - Pins 2 and 3 fixed level when off.
// - Reset: controls 0,1,2,4 low, 3 high.
// - Each control has a level per mode.
// - Button steps down per refresh to sleep.
// - Button from sleep, suspend, off: high speed.
`timescale 1ns/1ps
module pmpc_top
	import pmpc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ac_power_present,
	input wire logic i_battery_low_1,
	input wire logic i_battery_low_2,
	input wire logic i_battery_low_3,
	input wire logic i_battery_low_4,
	input wire logic i_external_mgmt_irq_in,
	input wire logic i_suspend_resume_in,
	input wire logic i_refresh_tick,
	input wire logic i_ac_override_en,
	input wire logic [3:0] i_bl_enable,
	input wire logic i_bl1_to_irq,
	input wire logic i_bl2_to_irq,
	input wire logic i_ext_rising,
	input wire logic i_ext_enable,
	input wire logic i_sw_mode_req,
	input wire logic [2:0] i_sw_mode,
	input wire logic i_irq_clear,
	input wire logic [3:0] i_irq_clear_mask,
	input wire logic [4:0] i_pc_level_high_speed,
	input wire logic [4:0] i_pc_level_low_speed,
	input wire logic [4:0] i_pc_level_doze,
	input wire logic [4:0] i_pc_level_sleep,
	input wire logic [4:0] i_pc_level_suspend,
	input wire logic [4:0] i_pc_level_off,
	input wire logic i_pc_program_en,
	input wire logic [3:0] i_sel_cs_mode,
	input wire logic [3:0] i_sel_strobe_gate,
	input wire logic [1:0] i_sel_direct_en,
	input wire logic [1:0] i_sel_direct_bit,
	input wire logic [1:0] i_sel_dir_out,
	input wire logic [3:2] i_sel_off_force,
	input wire logic [3:2] i_sel_off_level,
	input wire logic [3:0] i_decode_hit,
	input wire logic i_io_write_strobe,
	input wire logic i_io_read_strobe,
	input wire logic [3:0] i_prog_select_pins_in,
	output logic o_mgmt_interrupt_request,
	output logic [3:0] o_mgmt_irq_flags,
	output logic o_latched_power_ctrl_n,
	output logic [4:0] o_power_ctrl_outputs,
	output logic [3:0] o_prog_select_pins_out,
	output logic [3:0] o_prog_select_pins_oe,
	output logic [3:0] o_prog_select_pins_in,
	output logic [2:0] o_mode
);

	logic [3:0] bl_level;
	logic [3:0] bl_fall;
	logic ext_rise;
	logic ext_fall;
	logic sr_rise;
	logic [3:0] sel_in_meta;
	logic [3:0] sel_in_sync;

	logic [3:0] bl_async;
	assign bl_async = {i_battery_low_4, i_battery_low_3, i_battery_low_2,
		i_battery_low_1};

	// One synchroniser for each battery-low input.
	genvar g;
	generate
		for (g = 0; g < PMPC_NUM_BL; g++) begin : g_bl
			pmpc_sync_edge u_sync (
				.i_clk(i_clk),
				.i_rst(i_rst),
				.i_async(bl_async[g]),
				.o_level(bl_level[g]),
				.o_rise(),
				.o_fall(bl_fall[g])
			);
		end
	endgenerate

	// Only the edges of the external and button inputs are used.
	pmpc_sync_edge u_sync_ext (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_external_mgmt_irq_in),
		.o_level(),
		.o_rise(ext_rise),
		.o_fall(ext_fall)
	);

	pmpc_sync_edge u_sync_sr (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_suspend_resume_in),
		.o_level(),
		.o_rise(sr_rise),
		.o_fall()
	);

	logic ac_meta;
	logic ac_sync;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ac_meta <= 1'b0;
			ac_sync <= 1'b0;
			sel_in_meta <= 4'h0;
			sel_in_sync <= 4'h0;
		end else begin
			ac_meta <= i_ac_power_present;
			ac_sync <= ac_meta;
			sel_in_meta <= i_prog_select_pins_in;
			sel_in_sync <= sel_in_meta;
		end
	end

	// Management suppressed while on AC with override on.
	logic pm_active;
	assign pm_active = ~(ac_sync & i_ac_override_en);

	logic [3:0] bl_evt;
	assign bl_evt = bl_fall & i_bl_enable & {4{pm_active}};

	// Active edge chosen by polarity setting.
	logic ext_evt;
	assign ext_evt = pm_active & i_ext_enable &
		(i_ext_rising ? ext_rise : ext_fall);

	logic [3:0] irq_set;
	always_comb begin
		irq_set = 4'h0;
		irq_set[PMPC_SRC_BL1] = bl_evt[0] & i_bl1_to_irq;
		irq_set[PMPC_SRC_BL2] = bl_evt[1] & i_bl2_to_irq;
		irq_set[PMPC_SRC_BL3] = bl_evt[2];
		irq_set[PMPC_SRC_EXT] = ext_evt;
	end

	logic [3:0] irq_flags;
	// Sticky flags; a new event beats a clear.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_flags <= 4'h0;
		end else begin
			irq_flags <= (irq_flags & ~({4{i_irq_clear}} & i_irq_clear_mask))
				| irq_set;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mgmt_interrupt_request <= 1'b0;
			o_mgmt_irq_flags <= 4'h0;
		end else begin
			o_mgmt_interrupt_request <= |irq_flags;
			o_mgmt_irq_flags <= irq_flags;
		end
	end

	pmpc_mode_t mode;
	pmpc_mode_t next_mode;
	logic stepping;
	logic next_stepping;

	always_comb begin
		next_mode = mode;
		next_stepping = stepping;
		// One step down per refresh tick.
		if (stepping && i_refresh_tick) begin
			case (mode)
				PMPC_HIGH_SPEED: next_mode = PMPC_LOW_SPEED;
				PMPC_LOW_SPEED: next_mode = PMPC_DOZE;
				PMPC_DOZE: next_mode = PMPC_SLEEP;
				default: next_mode = mode;
			endcase
			if (next_mode == PMPC_SLEEP || mode == PMPC_SLEEP) begin
				next_stepping = 1'b0;
			end
		end
		// Codes above Off are no mode and give the reset control levels.
		if (i_sw_mode_req) begin
			next_mode = pmpc_mode_t'(i_sw_mode);
			next_stepping = 1'b0;
		end
		// Battery-low 1 drops to low speed.
		if (bl_evt[0] && !i_bl1_to_irq && mode == PMPC_HIGH_SPEED) begin
			next_mode = PMPC_LOW_SPEED;
		end
		// Battery-low 2 enters sleep unless sleeping.
		if (bl_evt[1] && !i_bl2_to_irq && mode != PMPC_SLEEP) begin
			next_mode = PMPC_SLEEP;
			next_stepping = 1'b0;
		end
		if (pm_active && sr_rise) begin
			case (mode)
				PMPC_SLEEP, PMPC_SUSPEND, PMPC_OFF: begin
					next_mode = PMPC_HIGH_SPEED;
					next_stepping = 1'b0;
				end
				default: next_stepping = 1'b1;
			endcase
		end
		if (bl_evt[3]) begin
			next_mode = PMPC_SUSPEND;
			next_stepping = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode <= PMPC_HIGH_SPEED;
			stepping <= 1'b0;
		end else begin
			mode <= next_mode;
			stepping <= next_stepping;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mode <= 3'h0;
		end else begin
			o_mode <= next_mode;
		end
	end

	// Latched power follows inverse battery-low 4 while off AC and enabled.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_latched_power_ctrl_n <= 1'b1;
		end else if (!ac_sync && i_bl_enable[3]) begin
			o_latched_power_ctrl_n <= ~bl_level[3];
		end
	end

	logic [4:0] mode_levels;
	always_comb begin
		case (next_mode)
			PMPC_HIGH_SPEED: mode_levels = i_pc_level_high_speed;
			PMPC_LOW_SPEED: mode_levels = i_pc_level_low_speed;
			PMPC_DOZE: mode_levels = i_pc_level_doze;
			PMPC_SLEEP: mode_levels = i_pc_level_sleep;
			PMPC_SUSPEND: mode_levels = i_pc_level_suspend;
			PMPC_OFF: mode_levels = i_pc_level_off;
			default: mode_levels = PMPC_PC_RESET;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_power_ctrl_outputs <= PMPC_PC_RESET;
		end else if (i_pc_program_en) begin
			o_power_ctrl_outputs <= mode_levels;
		end
	end

	logic [3:0] sel_level;
	logic [3:0] sel_strobe;
	logic [3:0] sel_off_force;
	logic [3:0] sel_off_level;
	logic [3:0] sel_direct_bit;
	logic in_off;
	assign in_off = (mode == PMPC_OFF);
	assign sel_strobe = {i_io_read_strobe, i_io_write_strobe,
		i_io_read_strobe, i_io_write_strobe};
	assign sel_off_force = {i_sel_off_force & {2{in_off}}, 2'h0};
	assign sel_off_level = {i_sel_off_level, 2'h0};
	assign sel_direct_bit = {2'h0, i_sel_direct_bit};

	function automatic logic [1:0] sel_mode_of(input logic gate,
		input logic direct);
		if (direct) begin
			sel_mode_of = PMPC_SEL_DIRECT;
		end else if (gate) begin
			sel_mode_of = PMPC_SEL_STROBE;
		end else begin
			sel_mode_of = PMPC_SEL_DECODE;
		end
	endfunction

	// Chip select applies the strobe gate; decoder uses decode alone.
	generate
		for (g = 0; g < PMPC_NUM_SEL; g++) begin : g_sel
			pmpc_select_pin u_pin (
				.i_sel_mode(sel_mode_of(i_sel_cs_mode[g] &
					i_sel_strobe_gate[g], (g < 2) ? i_sel_direct_en[g % 2]
					: 1'b0)),
				.i_decode_hit(i_decode_hit[g]),
				.i_strobe(sel_strobe[g]),
				.i_direct_bit(sel_direct_bit[g]),
				.i_direct_allowed(g < 2),
				.i_off_force(sel_off_force[g]),
				.i_off_level(sel_off_level[g]),
				.o_level(sel_level[g])
			);
		end
	endgenerate

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			// Pins 0,1 inputs after reset; 2,3 outputs.
			o_prog_select_pins_oe <= PMPC_SEL_DIR_RESET;
			o_prog_select_pins_out <= PMPC_SEL_OUT_RESET;
			o_prog_select_pins_in <= 4'h0;
		end else begin
			// Direction of pins 0,1 is programmable.
			o_prog_select_pins_oe <= {2'h3, i_sel_dir_out};
			o_prog_select_pins_out <= sel_level;
			o_prog_select_pins_in <= sel_in_sync;
		end
	end

endmodule

/* File: testbench/pmpc_pins_model.sv */
// Battery monitors, button, external source and AC sense driving the pins.
`timescale 1ns/1ps
module pmpc_pins_model (
	input wire logic i_clk,
	output logic [6:0] o_pins
);
	initial o_pins = 7'h0f;
	task automatic set_pin(input int k, input logic v);
		@(posedge i_clk);
		#1;
		o_pins[k] = v;
	endtask
endmodule

/* File: testbench/pmpc_properties.sv */
// Port checker for the power pin controller, bound into its top module.
`timescale 1ns/1ps
module pmpc_checker
	import pmpc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ac_power_present,
	input wire logic i_ac_override_en,
	input wire logic i_battery_low_4,
	input wire logic [3:0] i_bl_enable,
	input wire logic i_suspend_resume_in,
	input wire logic i_refresh_tick,
	input wire logic i_sw_mode_req,
	input wire logic i_irq_clear,
	input wire logic i_pc_program_en,
	input wire logic [3:2] i_sel_off_force,
	input wire logic [3:2] i_sel_off_level,
	input wire logic o_mgmt_interrupt_request,
	input wire logic [3:0] o_mgmt_irq_flags,
	input wire logic o_latched_power_ctrl_n,
	input wire logic [4:0] o_power_ctrl_outputs,
	input wire logic [3:0] o_prog_select_pins_out,
	input wire logic [3:0] o_prog_select_pins_oe,
	input wire logic [2:0] o_mode
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_wake;
		(o_mode >= PMPC_SLEEP && !i_ac_power_present)
		##1 $rose(i_suspend_resume_in);
	endsequence
	sequence s_muted;
		(i_ac_power_present && i_ac_override_en)[*4];
	endsequence
	// Set once the controls have been allowed to follow the mode.
	logic ever_prog;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ever_prog <= 1'b0;
		end else if (i_pc_program_en) begin
			ever_prog <= 1'b1;
		end
	end
	property p_pc_reset;
		!ever_prog |-> o_power_ctrl_outputs == PMPC_PC_RESET;
	endproperty
	a_pc_reset: assert property (p_pc_reset) else $error("pc not reset");
	property p_oe_fixed;
		o_prog_select_pins_oe[3:2] == 2'h3;
	endproperty
	a_oe_fixed: assert property (p_oe_fixed) else $error("oe 3:2 low");
	property p_req_or;
		o_mgmt_interrupt_request == |o_mgmt_irq_flags;
	endproperty
	a_req_or: assert property (p_req_or) else $error("request wrong");
	property p_flags_hold;
		!i_irq_clear && !$past(i_irq_clear) |=>
		(o_mgmt_irq_flags & $past(o_mgmt_irq_flags)) == $past(o_mgmt_irq_flags);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flag lost");
	property p_lph;
		(!i_ac_power_present && i_bl_enable[3] && $stable(i_battery_low_4))[*5]
		|-> o_latched_power_ctrl_n == !i_battery_low_4;
	endproperty
	a_lph: assert property (p_lph) else $error("lph wrong");
	property p_off_level;
		(o_mode == PMPC_OFF && i_sel_off_force == 2'h3
		&& $stable(i_sel_off_level))[*3]
		|-> o_prog_select_pins_out[3:2] == i_sel_off_level;
	endproperty
	a_off_level: assert property (p_off_level) else $error("off level");
	property p_wake;
		s_wake |-> ##[1:5] o_mode == PMPC_HIGH_SPEED;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_doze_by_tick;
		o_mode == PMPC_DOZE && $past(o_mode) != PMPC_DOZE
		|-> $past(i_refresh_tick) || $past(i_sw_mode_req);
	endproperty
	a_doze_by_tick: assert property (p_doze_by_tick) else $error("doze");
	property p_muted;
		s_muted |=> (o_mgmt_irq_flags & ~$past(o_mgmt_irq_flags)) == 4'h0;
	endproperty
	a_muted: assert property (p_muted) else $error("flag while muted");
endmodule
bind pmpc_top pmpc_checker u_chk (.*);

/* File: testbench/tb.sv */
// Self-checking bench for the power pin controller.
`timescale 1ns/1ps
module tb
	import pmpc_pkg::*;
;
	logic i_clk = 1'h0, i_rst = 1'h1, i_refresh_tick = 1'h0;
	logic i_ac_override_en = 1'h1, i_bl1_to_irq = 1'h0, i_bl2_to_irq = 1'h0;
	logic i_ext_rising = 1'h1, i_ext_enable = 1'h1, i_sw_mode_req = 1'h0;
	logic i_irq_clear = 1'h0, i_pc_program_en = 1'h0;
	logic i_io_write_strobe = 1'h0, i_io_read_strobe = 1'h0;
	logic [2:0] i_sw_mode = 3'h0;
	logic [3:0] i_bl_enable = 4'hf, i_irq_clear_mask = 4'hf;
	logic [3:0] i_sel_cs_mode = 4'h0, i_sel_strobe_gate = 4'h0;
	logic [3:0] i_decode_hit = 4'h0, i_prog_select_pins_in = 4'h9;
	logic [1:0] i_sel_direct_en = 2'h0, i_sel_direct_bit = 2'h0;
	logic [1:0] i_sel_dir_out = 2'h0;
	logic [3:2] i_sel_off_force = 2'h0, i_sel_off_level = 2'h0;
	logic [4:0] lv [6] = '{5'h11, 5'h02, 5'h04, 5'h19, 5'h0a, 5'h15};
	wire logic [4:0] i_pc_level_high_speed = lv[0];
	wire logic [4:0] i_pc_level_low_speed = lv[1];
	wire logic [4:0] i_pc_level_doze = lv[2];
	wire logic [4:0] i_pc_level_sleep = lv[3];
	wire logic [4:0] i_pc_level_suspend = lv[4];
	wire logic [4:0] i_pc_level_off = lv[5];
	wire logic [6:0] pins;
	wire logic i_ac_power_present, i_suspend_resume_in, i_external_mgmt_irq_in;
	wire logic i_battery_low_4, i_battery_low_3;
	wire logic i_battery_low_2, i_battery_low_1;
	logic o_mgmt_interrupt_request, o_latched_power_ctrl_n;
	logic [3:0] o_mgmt_irq_flags, o_prog_select_pins_out;
	logic [3:0] o_prog_select_pins_oe, o_prog_select_pins_in;
	logic [4:0] o_power_ctrl_outputs;
	logic [2:0] o_mode;
	int n_mismatch = 0, compares = 0;
	assign {i_ac_power_present, i_suspend_resume_in, i_external_mgmt_irq_in,
		i_battery_low_4, i_battery_low_3, i_battery_low_2,
		i_battery_low_1} = pins;
	pmpc_pins_model pm (.i_clk(i_clk), .o_pins(pins));
	pmpc_top uut (.*);
	initial forever #4 i_clk = ~i_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			$display("FAIL %s exp %h got %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic sw(input logic [2:0] m);
		i_sw_mode = m;
		i_sw_mode_req = 1'h1;
		tick(1);
		i_sw_mode_req = 1'h0;
		tick(2);
	endtask
	task automatic refresh;
		i_refresh_tick = 1'h1;
		tick(1);
		i_refresh_tick = 1'h0;
		tick(1);
	endtask
	task automatic clr(input logic [3:0] m);
		i_irq_clear_mask = m;
		i_irq_clear = 1'h1;
		tick(1);
		i_irq_clear = 1'h0;
		tick(2);
	endtask
	task automatic pin(input int k, input logic v);
		pm.set_pin(k, v);
		tick(6);
	endtask
	task automatic fall(input int k);
		pin(k, 1'h0);
		pin(k, 1'h1);
	endtask
	task automatic t_reset;
		chk("pc", PMPC_PC_RESET, o_power_ctrl_outputs);
		chk("oe", PMPC_SEL_DIR_RESET, o_prog_select_pins_oe);
	endtask
	task automatic t_modes;
		i_pc_program_en = 1'h1;
		for (int m = 0; m < 6; m++) begin
			sw(3'(m));
			chk("pc", lv[m], o_power_ctrl_outputs);
		end
	endtask
	task automatic t_button;
		sw(PMPC_HIGH_SPEED);
		pin(5, 1'h1);
		chk("hold", PMPC_HIGH_SPEED, o_mode);
		for (int k = 1; k < 5; k++) begin
			refresh();
			chk("step", (k > 3) ? 8'h3 : 8'(k), o_mode);
		end
		for (int m = 3; m < 6; m++) begin
			sw(3'(m));
			pin(5, 1'h0);
			pin(5, 1'h1);
			chk("wake", PMPC_HIGH_SPEED, o_mode);
		end
		pin(5, 1'h0);
	endtask
	task automatic t_bl;
		sw(PMPC_HIGH_SPEED);
		fall(0);
		chk("bl1", PMPC_LOW_SPEED, o_mode);
		sw(PMPC_HIGH_SPEED);
		fall(1);
		chk("bl2", PMPC_SLEEP, o_mode);
		sw(PMPC_HIGH_SPEED);
		i_bl1_to_irq = 1'h1;
		i_bl2_to_irq = 1'h1;
		fall(0);
		fall(1);
		fall(2);
		chk("flags", 8'h7, o_mgmt_irq_flags);
		chk("bl3", PMPC_HIGH_SPEED, o_mode);
		chk("req", 8'h1, o_mgmt_interrupt_request);
		clr(4'h1);
		chk("clr", 8'h6, o_mgmt_irq_flags);
		clr(4'hf);
		chk("req", 8'h0, o_mgmt_interrupt_request);
	endtask
	task automatic t_ext;
		for (int p = 0; p < 2; p++) begin
			i_ext_rising = 1'(p);
			pin(4, 1'h1);
			chk("ext", (p == 1) ? 8'h8 : 8'h0, o_mgmt_irq_flags);
			clr(4'hf);
			pin(4, 1'h0);
			chk("ext", (p == 0) ? 8'h8 : 8'h0, o_mgmt_irq_flags);
			clr(4'hf);
		end
	endtask
	task automatic t_power;
		pin(3, 1'h0);
		chk("lph", 8'h1, o_latched_power_ctrl_n);
		chk("bl4", PMPC_SUSPEND, o_mode);
		pin(3, 1'h1);
		chk("lph", 8'h0, o_latched_power_ctrl_n);
		pin(6, 1'h1);
		fall(2);
		chk("muted", 8'h0, o_mgmt_irq_flags);
		i_ac_override_en = 1'h0;
		fall(2);
		chk("unmuted", 8'h4, o_mgmt_irq_flags);
		clr(4'hf);
		i_ac_override_en = 1'h1;
		pin(6, 1'h0);
	endtask
	task automatic t_sel;
		i_decode_hit = 4'h5;
		tick(3);
		chk("dec", 8'h5, o_prog_select_pins_out);
		i_sel_cs_mode = 4'hf;
		i_sel_strobe_gate = 4'hf;
		i_decode_hit = 4'hf;
		i_io_write_strobe = 1'h1;
		tick(3);
		chk("wr", 8'h5, o_prog_select_pins_out);
		i_io_write_strobe = 1'h0;
		i_io_read_strobe = 1'h1;
		tick(3);
		chk("rd", 8'ha, o_prog_select_pins_out);
		i_sel_direct_en = 2'h3;
		i_sel_direct_bit = 2'h1;
		i_sel_dir_out = 2'h3;
		tick(3);
		chk("dir", 8'h9, o_prog_select_pins_out);
		chk("oe", 8'hf, o_prog_select_pins_oe);
		chk("pin in", 8'h9, o_prog_select_pins_in);
		sw(PMPC_OFF);
		i_sel_off_force = 2'h3;
		i_sel_off_level = 2'h1;
		tick(3);
		chk("off", 8'h5, o_prog_select_pins_out);
	endtask
	task automatic stop_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge i_clk);
		#1;
		i_rst = 1'h0;
		tick(1);
		t_reset();
		t_modes();
		t_button();
		t_bl();
		t_ext();
		t_power();
		t_sel();
		stop_test();
	end
endmodule
